// ### logic/tpgil_regs.svh
// timing and sizing constants for the three-phase gate command controller
// assumes a single 250 MHz clock; all times are turned into cycle counts here
`ifndef TPGIL_REGS_SVH
`define TPGIL_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// clock and phase count
`define TPGIL_CLK_KHZ          250000
`define TPGIL_PHASES           3

////////////////////////////////////////////////////////////////////////////////
// switching times: least times round up to whole cycles
`define TPGIL_DEAD_NS          1500
`define TPGIL_MIN_PULSE_NS     500
`define TPGIL_DEAD_CYC         ((`TPGIL_DEAD_NS * `TPGIL_CLK_KHZ + 999999) / 1000000)
`define TPGIL_MIN_CYC          ((`TPGIL_MIN_PULSE_NS * `TPGIL_CLK_KHZ + 999999) / 1000000)

////////////////////////////////////////////////////////////////////////////////
// carrier: highest frequency gives the shortest period, rounded up
`define TPGIL_CARRIER_MAX_KHZ  20
`define TPGIL_CARRIER_CYC      ((`TPGIL_CLK_KHZ + `TPGIL_CARRIER_MAX_KHZ - 1) / `TPGIL_CARRIER_MAX_KHZ)

////////////////////////////////////////////////////////////////////////////////
// bootstrap charge at startup, short for small capacitors, long for the largest
`define TPGIL_CHARGE_SHORT_MS  500
`define TPGIL_CHARGE_LONG_MS   1000
`define TPGIL_CHARGE_SHORT_CYC (`TPGIL_CHARGE_SHORT_MS * `TPGIL_CLK_KHZ)
`define TPGIL_CHARGE_LONG_CYC  (`TPGIL_CHARGE_LONG_MS * `TPGIL_CLK_KHZ)

////////////////////////////////////////////////////////////////////////////////
// low-side off limit: capacitance in uF must exceed ratio times off time in s
`define TPGIL_BOOT_UF          10
`define TPGIL_BOOT_RATIO       800
`define TPGIL_LOFF_MAX_US      (`TPGIL_BOOT_UF * 1000000 / `TPGIL_BOOT_RATIO)
`define TPGIL_LOFF_MAX_CYC     (`TPGIL_LOFF_MAX_US * (`TPGIL_CLK_KHZ / 1000))

`endif

// ### logic/tpgil_pkg.sv
// types shared by the gate command controller and its phase sequencer
// assumes nothing beyond the timing header
package tpgil_pkg;

  // per-phase switching states
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_LOW_ON,
    PH_DEAD_H,
    PH_HIGH_ON,
    PH_DEAD_L
  } tpgil_phase_state_t;

  // whole state of one phase sequencer
  typedef struct packed {
    tpgil_phase_state_t st;
    logic [31:0]        tmr;
    logic [31:0]        loff;
    logic               hs;
    logic               ls;
  } tpgil_phase_q_t;

  // commands from the sequencer to one phase
  typedef struct packed {
    logic en;
    logic want_high;
    logic force_low;
    logic force_off;
  } tpgil_phase_ctl_t;

  // power sequencing states
  typedef enum logic [2:0] {
    CT_WAIT_SUPPLY,
    CT_CHARGE,
    CT_RUN,
    CT_STOP,
    CT_OFF
  } tpgil_ctrl_state_t;

  // whole state of the top controller
  typedef struct packed {
    tpgil_ctrl_state_t st;
    logic [31:0]       chg;
    logic [31:0]       car;
    logic              long_chg;
    logic              oe_n;
    logic              rel;
    logic              run;
  } tpgil_ctrl_q_t;

endpackage : tpgil_pkg

// ### logic/tpgil_phase.sv
// one phase of the gate command generator: dead time, least pulse width,
// bootstrap refresh; assumes a synchronised active-low reset from the top
`timescale 1ns/1ps
`default_nettype none
`include "tpgil_regs.svh"

module tpgil_phase #(
  parameter int unsigned DEAD_CYC     = `TPGIL_DEAD_CYC,
  parameter int unsigned MIN_CYC      = `TPGIL_MIN_CYC,
  parameter int unsigned LOFF_MAX_CYC = `TPGIL_LOFF_MAX_CYC,
  parameter int unsigned REFRESH_CYC  = `TPGIL_LOFF_MAX_CYC - 2 * (`TPGIL_DEAD_CYC + `TPGIL_MIN_CYC)
) (
  // clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  // commands
  input  wire tpgil_pkg::tpgil_phase_ctl_t ctl_i,
  // gate commands and status
  output logic                             high_side_cmd_o,
  output logic                             low_side_cmd_o,
  output logic                             idle_o
);

  tpgil_pkg::tpgil_phase_q_t     q;
  tpgil_pkg::tpgil_phase_q_t     d;
  tpgil_pkg::tpgil_phase_state_t nxt;
  logic                          want;
  logic                          stay_low;
  logic                          hold_ok;
  logic                          dead_ok;

  //////////////////////////////////////////////////////////////////////////////
  // next state: a side turns on only after a full dead interval with both off
  always_comb begin
    d        = q;
    hold_ok  = q.tmr >= 32'(MIN_CYC - 1);
    dead_ok  = q.tmr >= 32'(DEAD_CYC - 1);
    // drop the high request when the capacitor has gone too long uncharged
    want     = ctl_i.want_high && (q.loff < 32'(REFRESH_CYC));
    stay_low = ctl_i.force_off || ctl_i.force_low || !ctl_i.en || !want;
    nxt      = q.st;
    unique case (q.st)
      tpgil_pkg::PH_IDLE: begin
        if (q.tmr >= 32'(DEAD_CYC) && !ctl_i.force_off && (ctl_i.force_low || ctl_i.en)) begin
          nxt = tpgil_pkg::PH_LOW_ON;
        end
      end
      tpgil_pkg::PH_LOW_ON: begin
        if (hold_ok && ctl_i.force_off) begin
          nxt = tpgil_pkg::PH_IDLE;
        end else if (hold_ok && !stay_low) begin
          nxt = tpgil_pkg::PH_DEAD_H;
        end
      end
      tpgil_pkg::PH_DEAD_H: begin
        if (dead_ok) begin
          if (ctl_i.force_off) begin
            nxt = tpgil_pkg::PH_IDLE;
          end else if (stay_low) begin
            nxt = tpgil_pkg::PH_LOW_ON;
          end else begin
            nxt = tpgil_pkg::PH_HIGH_ON;
          end
        end
      end
      tpgil_pkg::PH_HIGH_ON: begin
        if (hold_ok && stay_low) begin
          nxt = tpgil_pkg::PH_DEAD_L;
        end
      end
      tpgil_pkg::PH_DEAD_L: begin
        if (dead_ok) begin
          nxt = ctl_i.force_off ? tpgil_pkg::PH_IDLE : tpgil_pkg::PH_LOW_ON;
        end
      end
      default: nxt = tpgil_pkg::PH_IDLE;
    endcase
    d.st   = nxt;
    d.tmr  = (nxt != q.st) ? 32'h0 : ((q.tmr == 32'hffffffff) ? q.tmr : q.tmr + 32'h1);
    d.hs   = (nxt == tpgil_pkg::PH_HIGH_ON);
    d.ls   = (nxt == tpgil_pkg::PH_LOW_ON);
    d.loff = d.ls ? 32'h0 : ((q.loff == 32'hffffffff) ? q.loff : q.loff + 32'h1);
  end

  // state register; reset leaves both sides off
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign high_side_cmd_o = q.hs;
  assign low_side_cmd_o  = q.ls;
  assign idle_o          = (q.st == tpgil_pkg::PH_IDLE);

  //////////////////////////////////////////////////////////////////////////////
  // checking helpers: both-off gap and on-length of each side
  logic [31:0] gap_q;
  logic [31:0] hlen_q;
  logic [31:0] llen_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gap_q  <= 32'h0;
      hlen_q <= 32'h0;
      llen_q <= 32'h0;
    end else begin
      gap_q  <= (!q.hs && !q.ls) ? gap_q + 32'h1 : 32'h0;
      hlen_q <= q.hs ? hlen_q + 32'h1 : 32'h0;
      llen_q <= q.ls ? llen_q + 32'h1 : 32'h0;
    end
  end

  sequence both_off_s;
    gap_q >= 32'(DEAD_CYC);
  endsequence

  no_shoot_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !(high_side_cmd_o && low_side_cmd_o)) else $error("both sides of a phase on");
  dead_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(high_side_cmd_o) |-> both_off_s) else $error("high side on too soon");
  dead_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $rose(low_side_cmd_o) |-> both_off_s) else $error("low side on too soon");
  min_high_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(high_side_cmd_o) |-> hlen_q >= 32'(MIN_CYC)) else $error("short high pulse");
  min_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    $fell(low_side_cmd_o) |-> llen_q >= 32'(MIN_CYC)) else $error("short low pulse");
  low_off_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ctl_i.en |-> q.loff < 32'(LOFF_MAX_CYC)) else $error("low side off too long");

endmodule : tpgil_phase
`default_nettype wire

// ### logic/tpgil_ctrl.sv
// top of the three-phase gate command controller: power sequencing,
// bootstrap charge, carrier and per-phase duty compare
// assumes synchronous inputs from the motor control logic and a supply monitor
`timescale 1ns/1ps
`default_nettype none
`include "tpgil_regs.svh"

module tpgil_ctrl #(
  parameter int unsigned DUTY_W           = 16,
  parameter int unsigned CARRIER_CYC      = `TPGIL_CARRIER_CYC,
  parameter int unsigned CHARGE_SHORT_CYC = `TPGIL_CHARGE_SHORT_CYC,
  parameter int unsigned CHARGE_LONG_CYC  = `TPGIL_CHARGE_LONG_CYC,
  parameter int unsigned LOFF_MAX_CYC     = `TPGIL_LOFF_MAX_CYC
) (
  // clock and reset
  input  wire logic                                   mclk_i,
  input  wire logic                                   resetn_i,
  // power and run control
  input  wire logic                                   supply_good_i,
  input  wire logic                                   run_i,
  input  wire logic                                   charge_long_i,
  // per-phase duty, counts of the carrier period with high side requested
  input  wire logic [`TPGIL_PHASES-1:0][DUTY_W-1:0]   duty_i,
  // gate command pins
  output logic      [`TPGIL_PHASES-1:0]               high_side_cmd_o,
  output logic      [`TPGIL_PHASES-1:0]               low_side_cmd_o,
  output logic                                        cmd_oe_n_o,
  // status
  output logic                                        supply_release_o,
  output logic                                        running_o
);

  localparam int unsigned NPH      = `TPGIL_PHASES;
  localparam int unsigned DEAD_CYC = `TPGIL_DEAD_CYC;
  localparam int unsigned MIN_CYC  = `TPGIL_MIN_CYC;
  // leave room in every period for dead, low pulse and dead again
  localparam int unsigned DUTY_MAX = CARRIER_CYC - 2 * (DEAD_CYC + MIN_CYC);
  // refresh early enough that the forced low-side turn-on lands inside the limit
  localparam int unsigned REFRESH_CYC = LOFF_MAX_CYC - 2 * (DEAD_CYC + MIN_CYC);

  localparam tpgil_pkg::tpgil_ctrl_q_t RESET_Q = '{
    st:       tpgil_pkg::CT_WAIT_SUPPLY,
    chg:      32'h0,
    car:      32'h0,
    long_chg: 1'b0,
    oe_n:     1'b1,
    rel:      1'b0,
    run:      1'b0
  };

  //////////////////////////////////////////////////////////////////////////////
  // reset release through two flip-flops; assertion stays asynchronous
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // state
  tpgil_pkg::tpgil_ctrl_q_t q;
  tpgil_pkg::tpgil_ctrl_q_t d;
  logic [NPH-1:0]           hs_w;
  logic [NPH-1:0]           ls_w;
  logic [NPH-1:0]           idle_w;
  logic                     all_low_on;
  logic                     all_idle;
  logic [31:0]              chg_tgt;

  assign all_low_on = &ls_w;
  assign all_idle   = (&idle_w) && (hs_w == '0) && (ls_w == '0);
  assign chg_tgt    = q.long_chg ? 32'(CHARGE_LONG_CYC) : 32'(CHARGE_SHORT_CYC);

  //////////////////////////////////////////////////////////////////////////////
  // sequencing: wait for supply, charge, run, stop, released
  always_comb begin
    d = q;
    // sawtooth carrier, period never shorter than the fastest allowed
    d.car = (q.car >= 32'(CARRIER_CYC - 1)) ? 32'h0 : q.car + 32'h1;
    unique case (q.st)
      tpgil_pkg::CT_WAIT_SUPPLY: begin
        d.oe_n = 1'b1;
        d.rel  = 1'b0;
        if (supply_good_i && run_i) begin
          d.st       = tpgil_pkg::CT_CHARGE;
          d.oe_n     = 1'b0;
          d.chg      = 32'h0;
          d.long_chg = charge_long_i;
        end
      end
      tpgil_pkg::CT_CHARGE: begin
        if (!run_i || !supply_good_i) begin
          d.st = tpgil_pkg::CT_STOP;
        end else if (all_low_on) begin
          // only time with every low side actually on counts as charging
          if (q.chg >= chg_tgt - 32'h1) begin
            d.st  = tpgil_pkg::CT_RUN;
            d.run = 1'b1;
          end else begin
            d.chg = q.chg + 32'h1;
          end
        end
      end
      tpgil_pkg::CT_RUN: begin
        if (!run_i || !supply_good_i) begin
          d.st  = tpgil_pkg::CT_STOP;
          d.run = 1'b0;
        end
      end
      tpgil_pkg::CT_STOP: begin
        // supply may only be lowered once every command line sits low
        if (all_idle) begin
          d.st  = tpgil_pkg::CT_OFF;
          d.rel = 1'b1;
        end
      end
      tpgil_pkg::CT_OFF: begin
        if (!supply_good_i) begin
          d.st   = tpgil_pkg::CT_WAIT_SUPPLY;
          d.oe_n = 1'b1;
          d.rel  = 1'b0;
        end else if (run_i) begin
          d.st       = tpgil_pkg::CT_CHARGE;
          d.rel      = 1'b0;
          d.chg      = 32'h0;
          d.long_chg = charge_long_i;
        end
      end
      default: d = RESET_Q;
    endcase
  end

  // state register
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= RESET_Q;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // phases: duty compare against the carrier, clamped so low side runs each period
  for (genvar i = 0; i < NPH; i++) begin : g_phase
    tpgil_pkg::tpgil_phase_ctl_t ctl;

    assign ctl.en        = (q.st == tpgil_pkg::CT_RUN);
    assign ctl.want_high = (q.car < 32'(duty_i[i])) && (q.car < 32'(DUTY_MAX));
    assign ctl.force_low = (q.st == tpgil_pkg::CT_CHARGE);
    assign ctl.force_off = (q.st == tpgil_pkg::CT_STOP) || (q.st == tpgil_pkg::CT_OFF)
                           || (q.st == tpgil_pkg::CT_WAIT_SUPPLY);

    tpgil_phase #(
      .DEAD_CYC     (DEAD_CYC),
      .MIN_CYC      (MIN_CYC),
      .LOFF_MAX_CYC (LOFF_MAX_CYC),
      .REFRESH_CYC  (REFRESH_CYC)
    ) u_phase (
      .mclk_i          (mclk_i),
      .rst_n_i         (rst_n),
      .ctl_i           (ctl),
      .high_side_cmd_o (hs_w[i]),
      .low_side_cmd_o  (ls_w[i]),
      .idle_o          (idle_w[i])
    );
  end

  // outputs come straight from the phase and state flip-flops
  assign high_side_cmd_o  = hs_w;
  assign low_side_cmd_o   = ls_w;
  assign cmd_oe_n_o       = q.oe_n;
  assign supply_release_o = q.rel;
  assign running_o        = q.run;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence lines_low_s;
    (high_side_cmd_o == '0) && (low_side_cmd_o == '0);
  endsequence

  sequence drive_start_s;
    $fell(cmd_oe_n_o);
  endsequence

  undriven_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    cmd_oe_n_o |-> lines_low_s) else $error("lines active while undriven");
  drive_start_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    drive_start_s |-> $past(supply_good_i) ##1 !cmd_oe_n_o) else $error("drive before supply");
  release_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    supply_release_o |-> lines_low_s) else $error("supply released with line high");
  charge_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (q.st == tpgil_pkg::CT_CHARGE && q.chg != 32'h0) |-> (&low_side_cmd_o))
    else $error("low side dropped while charging");
  charge_done_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(running_o) |-> $past(q.chg) >= $past(chg_tgt) - 32'h1) else $error("run before charge");
  carrier_wrap_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (q.car == 32'(CARRIER_CYC - 1)) |=> (q.car == 32'h0)) else $error("carrier wrap wrong");
  carrier_span_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    q.car < 32'(CARRIER_CYC)) else $error("carrier count out of range");
  drive_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (q.st != tpgil_pkg::CT_WAIT_SUPPLY) |-> !cmd_oe_n_o) else $error("lines released");
  shoot_top_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    (high_side_cmd_o & low_side_cmd_o) == '0) else $error("shoot-through commanded");

  // release may only follow a cycle with every phase idle and both sides off
  release_idle_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(supply_release_o) |-> $past(all_idle)) else $error("release before lines idle");
  // running starts only out of a cycle with every low side on
  run_after_low_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    $rose(running_o) |-> $past(&low_side_cmd_o)) else $error("run without low sides on");
  // a dropped run request leaves the running state on the next edge
  run_exit_a: assert property (@(posedge mclk_i) disable iff (!rst_n)
    ($fell(run_i) && running_o) |=> !running_o) else $error("run kept after request dropped");

endmodule : tpgil_ctrl
`default_nettype wire

// ### verification/tpgil_dev_model.sv
// model of the driven device's command inputs: pull-downs, edge-set high latch,
// bootstrap lockout; assumes its pins come straight from the controller
`timescale 1ns/1ps
`default_nettype none

module tpgil_dev_model (
  // command pins and their shared output enable
  input  wire logic [2:0] high_side_cmd_i,
  input  wire logic [2:0] low_side_cmd_i,
  input  wire logic       cmd_oe_n_i,
  // bootstrap supply at or below its stop level, per phase
  input  wire logic [2:0] bootstrap_low_i,
  // gate drives
  output logic      [2:0] high_gate_drive_o,
  output logic      [2:0] low_gate_drive_o
);
  logic [2:0] hs_pin;
  logic [2:0] ls_pin;
  logic [2:0] latch_q = 3'h0;
  logic [2:0] prev_q  = 3'h0;

  //////////////////////////////////////////////////////////////////////////////
  // released pins fall to the pull-down level, so they read as off
  assign hs_pin = cmd_oe_n_i ? 3'h0 : high_side_cmd_i;
  assign ls_pin = cmd_oe_n_i ? 3'h0 : low_side_cmd_i;

  // edges only: a level held high never sets a latch again by itself
  always @(hs_pin) begin
    for (int p = 0; p < 3; p++) begin
      if (hs_pin[p] === 1'b1 && prev_q[p] === 1'b0) begin
        latch_q[p] = 1'b1;
      end else if (hs_pin[p] === 1'b0 && prev_q[p] === 1'b1) begin
        latch_q[p] = 1'b0;
      end
    end
    prev_q = hs_pin;
  end

  // lockout overrides the latch; low side is not latched at all
  assign high_gate_drive_o = latch_q & ~bootstrap_low_i;
  assign low_gate_drive_o  = ls_pin;
endmodule : tpgil_dev_model
`default_nettype wire

// ### verification/tpgil_tb.sv
// self-checking bench for the gate command controller
// assumes the device model beside it and shortened carrier and charge counts
`timescale 1ns/1ps
`default_nettype none
`include "tpgil_regs.svh"

module tb;
  localparam int unsigned CAR  = 2000;
  localparam int unsigned CHS  = 50;
  localparam int unsigned CHL  = 100;
  localparam int unsigned LOFF = 4000;
  localparam int unsigned DEAD = `TPGIL_DEAD_CYC;
  localparam int unsigned MINP = `TPGIL_MIN_CYC;
  // stimulus
  logic             mclk_i        = 1'b0;
  logic             resetn_i      = 1'b0;
  logic             supply_good_i = 1'b0;
  logic             run_i         = 1'b0;
  logic             charge_long_i = 1'b0;
  logic [2:0][15:0] duty_i        = '0;
  logic [2:0]       lockout       = 3'h0;
  // observed
  logic [2:0]       hs, ls, hg, lg;
  logic             oe_n, rel, running, run_q, rel_q, ever_sg, ran, oe_n_seen;
  logic [2:0]       hs_q, ls_q;
  int unsigned      hon[3], hoff[3], lon[3], loff[3], hrise[3], chg;
  int               mismatches = 0;
  int               checks     = 0;
  logic [33:0]      notes[$];
  logic [31:0]      lfsr       = 32'h3f59;

  //////////////////////////////////////////////////////////////////////////////
  always #2 mclk_i = ~mclk_i;

  tpgil_ctrl #(.DUTY_W(16), .CARRIER_CYC(CAR), .CHARGE_SHORT_CYC(CHS),
    .CHARGE_LONG_CYC(CHL), .LOFF_MAX_CYC(LOFF)) uut (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .supply_good_i(supply_good_i), .run_i(run_i),
    .charge_long_i(charge_long_i), .duty_i(duty_i), .high_side_cmd_o(hs),
    .low_side_cmd_o(ls), .cmd_oe_n_o(oe_n), .supply_release_o(rel), .running_o(running));

  tpgil_dev_model dev (.high_side_cmd_i(hs), .low_side_cmd_i(ls), .cmd_oe_n_i(oe_n),
    .bootstrap_low_i(lockout), .high_gate_drive_o(hg), .low_gate_drive_o(lg));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // note the charge length, then wait for running under a bound
  task automatic start(input logic lng, input int unsigned cyc);
    int n = 0;
    notes.push_back({2'b10, 32'(cyc)});
    charge_long_i <= lng;
    supply_good_i <= 1'b1;
    run_i         <= 1'b1;
    while (n < 3000 && running !== 1'b1) begin
      @(posedge mclk_i);
      n++;
    end
    check(34'(running), 34'h1);
  endtask : start

  // random duties on two phases; the third asks beyond the top every period
  task automatic pwm(input int k);
    repeat (k) begin
      for (int p = 0; p < 2; p++) begin
        lfsr = lfsr_next(lfsr);
        duty_i[p] <= 16'(lfsr % CAR);
      end
      duty_i[2]  <= 16'hffff;
      lockout[0] <= ~lockout[0];
      repeat (CAR) @(posedge mclk_i);
    end
  endtask : pwm

  task automatic stop;
    int n = 0;
    notes.push_back(34'h0);
    notes.push_back({2'b01, 32'h0});
    run_i <= 1'b0;
    while (n < 3000 && rel !== 1'b1) begin
      @(posedge mclk_i);
      n++;
    end
    check(34'(rel), 34'h1);
  endtask : stop

  //////////////////////////////////////////////////////////////////////////////
  // watcher: per-cycle timing on the pins, queue compare on status changes
  always @(posedge mclk_i) begin
    if (resetn_i) begin
      for (int p = 0; p < 3; p++) begin
        check(34'(hs[p] & ls[p]), 34'h0);
        check(34'(hg[p] & lg[p]), 34'h0);
        if (hs[p] && !hs_q[p]) check(34'(loff[p] >= DEAD), 34'h1);
        if (ls[p] && !ls_q[p]) check(34'(hoff[p] >= DEAD), 34'h1);
        if (hs[p] !== hs_q[p]) check(34'((hs_q[p] ? hon[p] : hoff[p]) >= MINP), 34'h1);
        if (ls[p] !== ls_q[p]) check(34'((ls_q[p] ? lon[p] : loff[p]) >= MINP), 34'h1);
        // latest clamped rise of one period against the earliest of the next
        if (p < 2 && hs[p] && !hs_q[p]) check(34'(hrise[p] >= 3 * DEAD + 2 * MINP), 34'h1);
        if (running && !ls[p]) check(34'(loff[p] < LOFF), 34'h1);
        if (hs[p] && !hs_q[p]) hrise[p] = 0;
        else hrise[p]++;
        hon[p]  = hs[p] ? hon[p] + 1 : 0;
        hoff[p] = hs[p] ? 0 : hoff[p] + 1;
        lon[p]  = ls[p] ? lon[p] + 1 : 0;
        loff[p] = ls[p] ? 0 : loff[p] + 1;
      end
      if (!ever_sg) check(34'({oe_n, hs, ls}), 34'h40);
      if (ever_sg && supply_good_i && oe_n_seen) check(34'(oe_n), 34'h0);
      if (rel) check(34'({hs, ls}), 34'h0);
      if (!ran) check(34'(hs), 34'h0);
      if (running !== run_q || (rel && !rel_q)) begin
        check({running, rel, running ? chg : 32'h0},
              notes.size() > 0 ? notes.pop_front() : '1);
      end
      chg = (ls == 3'h7 && !running) ? chg + 1 : 0;
      if (running) ran = 1'b1;
      if (rel) ran = 1'b0;
      if (supply_good_i) ever_sg = 1'b1;
      if (!oe_n) oe_n_seen = 1'b1;
    end
    hs_q  = hs;
    ls_q  = ls;
    run_q = running;
    rel_q = rel;
  end

  //////////////////////////////////////////////////////////////////////////////
  // main sequence: wait without supply, two starts of both charge lengths
  initial begin
    ever_sg = 1'b0;
    ran     = 1'b0;
    oe_n_seen = 1'b0;
    for (int p = 0; p < 3; p++) begin
      {hon[p], lon[p], loff[p], hoff[p], hrise[p]} = {32'h0, 32'h0, DEAD, DEAD, CAR};
    end
    chg = 0;
    repeat (20) @(posedge mclk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    run_i <= 1'b1;
    repeat (50) @(posedge mclk_i);
    start(1'b0, CHS);
    pwm(5);
    stop();
    start(1'b1, CHL);
    pwm(2);
    stop();
    supply_good_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check(34'(oe_n), 34'h1);
    check(34'(notes.size()), 34'h0);
    finish_test();
  end

  // watchdog sized well beyond the sequence above
  initial begin
    repeat (60000) @(posedge mclk_i);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : tb
`default_nettype wire
